// >>> bench/mpc_bm.sv
// Two-wire bus master model on a pulled-up data line
module mpc_bm (
    // Clock
    input wire logic sys_clk,
    // Wire levels
    input wire logic sda_oe,
    output logic scl,
    output wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pull_low = 1'b0;
    initial scl = 1'b1;
    assign sda = !(pull_low || sda_oe);
    task automatic hold(input logic c, input logic d);
        @(negedge sys_clk);
        scl = c;
        pull_low = !d;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic start();
        hold(1'b1, 1'b1);
        hold(1'b1, 1'b0);
        hold(1'b0, 1'b0);
    endtask
    task automatic stop();
        hold(1'b0, 1'b0);
        hold(1'b1, 1'b0);
        hold(1'b1, 1'b1);
    endtask
    task automatic bit_x(input logic d, output logic r);
        hold(1'b0, d);
        hold(1'b1, d);
        r = sda;
        hold(1'b0, d);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
            output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(ack_in, ack);
    endtask
endmodule // mpc_bm

// >>> bench/mpc_margin_config_tb.sv
// Self-checking bench for the margin configuration block
module mpc_margin_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    wire scl_i, sda_i;
    logic sda_o, sda_oe, cfg_update, nb_ovp_sel, nb_pgood_sel, core_ovp_sel, core_pgood_sel;
    logic [5:0] nb_offset_code, core_offset_code;
    logic signed [10:0] nb_offset_mv, core_offset_mv;
    logic [9:0] nb_ovp_margin_mv, nb_pgood_hi_mv, nb_pgood_lo_mv, pgood_hyst_mv;
    logic [9:0] core_ovp_margin_mv, core_pgood_hi_mv, core_pgood_lo_mv;
    logic [11:0] ovp_floor_mv;
    logic [7:0] q0, q1;
    logic a;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int updates = 0;
    localparam logic [48:0] cfg_reset = {8'h00, 10'd250, 10'd250, 10'd300, 11'd0};
    logic [49:0] rows [6] = '{
        {1'b1, 8'hc5, 10'd500, 10'd300, 10'd350, 11'd125},
        {1'b0, 8'h20, 10'd250, 10'd250, 10'd300, -11'sd800},
        {1'b1, 8'h1f, 10'd250, 10'd250, 10'd300, 11'd775},
        {1'b0, 8'hbf, 10'd500, 10'd250, 10'd300, -11'sd25},
        {1'b1, 8'h40, 10'd250, 10'd300, 10'd350, 11'd0},
        {1'b0, 8'h01, 10'd250, 10'd250, 10'd300, 11'd25}};
    mpc_margin_config mpc_margin_config_i (.*);
    mpc_bm mpc_bm_i (.sys_clk, .sda_oe, .scl(scl_i), .sda(sda_i));
    always #5 sys_clk = ~sys_clk;
    function automatic logic [48:0] dec(input logic r);
        return r ? {core_ovp_sel, core_pgood_sel, core_offset_code, core_ovp_margin_mv,
            core_pgood_hi_mv, core_pgood_lo_mv, core_offset_mv} : {nb_ovp_sel, nb_pgood_sel,
            nb_offset_code, nb_ovp_margin_mv, nb_pgood_hi_mv, nb_pgood_lo_mv, nb_offset_mv};
    endfunction
    task automatic chk(input string n, input logic [48:0] e, input logic [48:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        rstn = 1'b0;
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic send(input logic [7:0] b, input logic exp_ack);
        mpc_bm_i.xfer(b, 1'b1, q0, a);
        chk("ack", exp_ack, a);
    endtask
    task automatic hdr(input logic [7:0] r);
        mpc_bm_i.start();
        send(8'h8c, 1'b0);
        send(r, 1'b0);
    endtask
    task automatic rd(input logic r);
        hdr({7'h00, r});
        mpc_bm_i.stop();
        mpc_bm_i.start();
        send(8'h8d, 1'b0);
        mpc_bm_i.xfer(8'hff, 1'b0, q0, a);
        mpc_bm_i.xfer(8'hff, 1'b1, q1, a);
        mpc_bm_i.stop();
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            give_verdict();
        end
    end
    always @(posedge sys_clk) begin
        if (cfg_update === 1'b1) begin
            updates++;
        end
    end
    initial begin
        do_reset();
        chk("fixed", {12'd1800, 10'd50, 2'b00}, {ovp_floor_mv, pgood_hyst_mv, sda_o, sda_oe});
        foreach (rows[i]) begin
            hdr({7'h00, rows[i][49]});
            send(rows[i][48:41], 1'b0);
            mpc_bm_i.stop();
            chk("decode", rows[i][48:0], dec(rows[i][49]));
            chk("other", i > 0 ? rows[i-1][48:0] : cfg_reset, dec(!rows[i][49]));
            chk("updates", 49'(i + 1), 49'(updates));
            rd(rows[i][49]);
            chk("read", rows[i][48:41], q0);
            chk("read next", rows[i][49] ? 8'h00 : rows[i-1][48:41], q1);
        end
        hdr(8'h00);
        send(8'h9a, 1'b0);
        send(8'h61, 1'b0);
        chk("staged", rows[5][48:0], dec(1'b0));
        mpc_bm_i.stop();
        chk("pair nb", {8'h9a, 10'd500, 10'd250, 10'd300, 11'd650}, dec(1'b0));
        chk("pair core", {8'h61, 10'd250, 10'd300, 10'd350, -11'sd775}, dec(1'b1));
        chk("updates", 49'd7, 49'(updates));
        mpc_bm_i.start();
        send(8'h8c, 1'b0);
        send(8'h02, 1'b1);
        mpc_bm_i.stop();
        mpc_bm_i.start();
        send(8'h8e, 1'b1);
        mpc_bm_i.stop();
        rd(1'b0);
        chk("kept nb", 8'h9a, q0);
        chk("kept core", 8'h61, q1);
        chk("no update", 49'd7, 49'(updates));
        do_reset();
        chk("reset nb", cfg_reset, dec(1'b0));
        chk("reset core", cfg_reset, dec(1'b1));
        give_verdict();
    end
endmodule // mpc_margin_config_tb

// >>> bench/mpc_margin_props.sv
// Port checks for the margin configuration block
module mpc_margin_props (
    // Clock, reset and bus
    input wire sys_clk, rstn, scl_i, sda_i, sda_o, sda_oe, cfg_update,
    // Decoded settings
    input wire nb_ovp_sel, nb_pgood_sel, core_ovp_sel, core_pgood_sel,
    input wire [5:0] nb_offset_code, core_offset_code,
    input wire signed [10:0] nb_offset_mv, core_offset_mv,
    input wire [9:0] nb_ovp_margin_mv, nb_pgood_hi_mv, nb_pgood_lo_mv,
    input wire [9:0] core_ovp_margin_mv, core_pgood_hi_mv, core_pgood_lo_mv,
    input wire [11:0] ovp_floor_mv,
    input wire [9:0] pgood_hyst_mv
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_nb_ovp_level: assert property (nb_ovp_margin_mv == (nb_ovp_sel ? 10'd500 : 10'd250))
        else $error("nb ovp margin");
    a_core_ovp_level: assert property (core_ovp_margin_mv == (core_ovp_sel ? 10'd500 : 10'd250))
        else $error("core ovp margin");
    a_nb_pgood_window: assert property ({nb_pgood_hi_mv, nb_pgood_lo_mv} ==
        (nb_pgood_sel ? {10'd300, 10'd350} : {10'd250, 10'd300})) else $error("nb pgood window");
    a_core_pgood_window: assert property ({core_pgood_hi_mv, core_pgood_lo_mv} ==
        (core_pgood_sel ? {10'd300, 10'd350} : {10'd250, 10'd300})) else $error("core window");
    a_nb_offset_scale: assert property (nb_offset_mv ==
        $signed({{5{nb_offset_code[5]}}, nb_offset_code}) * 11'sd25) else $error("nb offset");
    a_core_offset_scale: assert property (core_offset_mv ==
        $signed({{5{core_offset_code[5]}}, core_offset_code}) * 11'sd25) else $error("core offset");
    a_fixed_figures: assert property (ovp_floor_mv == 12'd1800 && pgood_hyst_mv == 10'd50)
        else $error("floor or hysteresis");
    a_settings_hold: assert property ($changed({nb_ovp_sel, nb_pgood_sel, nb_offset_code,
        core_ovp_sel, core_pgood_sel, core_offset_code}) |-> $past(cfg_update) || !$past(rstn))
        else $error("settings moved without commit");
    a_commit_on_stop: assert property (cfg_update |-> $past(scl_i, 2) && $past(sda_i, 2))
        else $error("commit without stop");
    a_update_pulse: assert property (cfg_update |=> !cfg_update ##1 !cfg_update)
        else $error("update pulse too long");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i && sda_o == 1'b0)
        else $error("data pulled while clock high");
    c_commit: cover property (cfg_update);
    c_ack: cover property ($rose(sda_oe));
    c_low_end: cover property (nb_offset_code == 6'h20);
endmodule // mpc_margin_props

bind mpc_margin_config mpc_margin_props mpc_margin_props_i (.sys_clk, .rstn, .scl_i, .sda_i,
    .sda_o, .sda_oe, .cfg_update, .nb_ovp_sel, .nb_pgood_sel, .core_ovp_sel, .core_pgood_sel,
    .nb_offset_code, .core_offset_code, .nb_offset_mv, .core_offset_mv, .nb_ovp_margin_mv,
    .nb_pgood_hi_mv, .nb_pgood_lo_mv, .core_ovp_margin_mv, .core_pgood_hi_mv,
    .core_pgood_lo_mv, .ovp_floor_mv, .pgood_hyst_mv);

// >>> common/mpc_map.vh
// Register map, field layout and decode figures of the margin configuration block
`ifndef MPC_MAP_VH
`define MPC_MAP_VH

// Bus slave address, register address bytes and register reset value
`define MPC_SLAVE_ADDR 7'h46
`define MPC_REG_NB 8'h00
`define MPC_REG_CORE 8'h01
`define MPC_CFG_RESET 8'h00

// Field positions
`define MPC_OVP_BIT 7
`define MPC_PG_BIT 6
`define MPC_OFS_MSB 5
`define MPC_OFS_LSB 0

// Trip margins above or below the nominal reference, OVP floor, pgood hysteresis and offset step, in mV
`define MPC_OVP_FLOOR_MV 12'd1800
`define MPC_OVP_LOW_MV 10'd250
`define MPC_OVP_HIGH_MV 10'd500
`define MPC_PG_HI_NARROW_MV 10'd250
`define MPC_PG_LO_NARROW_MV 10'd300
`define MPC_PG_HI_WIDE_MV 10'd300
`define MPC_PG_LO_WIDE_MV 10'd350
`define MPC_PG_HYST_MV 10'd50
`define MPC_OFS_STEP_MV 11'd25

`endif

// >>> hw/mpc_margin_config.v
// Two-wire configuration slave and field decode for both regulator outputs
`include "mpc_map.vh"

module mpc_margin_config #(
    parameter [6:0] SLAVE_ADDR = `MPC_SLAVE_ADDR
) (
    // Clock and power-on reset
    input wire sys_clk,
    input wire rstn,
    // Two-wire bus pins
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe,
    // Update strobe
    output reg cfg_update,
    // North-bridge settings
    output reg nb_ovp_sel,
    output reg nb_pgood_sel,
    output reg [5:0] nb_offset_code,
    output reg signed [10:0] nb_offset_mv,
    output reg [9:0] nb_ovp_margin_mv,
    output reg [9:0] nb_pgood_hi_mv,
    output reg [9:0] nb_pgood_lo_mv,
    // Core settings
    output reg core_ovp_sel,
    output reg core_pgood_sel,
    output reg [5:0] core_offset_code,
    output reg signed [10:0] core_offset_mv,
    output reg [9:0] core_ovp_margin_mv,
    output reg [9:0] core_pgood_hi_mv,
    output reg [9:0] core_pgood_lo_mv,
    // Shared figures
    output reg [11:0] ovp_floor_mv,
    output reg [9:0] pgood_hyst_mv
);

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DEV = 3'd1;
    localparam [2:0] ST_REG = 3'd2;
    localparam [2:0] ST_WDAT = 3'd3;
    localparam [2:0] ST_RDAT = 3'd4;

    // Offset code to signed millivolts
    function signed [10:0] offset_mv;
        input [5:0] code;
        reg signed [10:0] ext;
        begin
            ext = {{5{code[5]}}, code};
            offset_mv = (ext <<< 4) + (ext <<< 3) + ext;
        end
    endfunction

    function [9:0] ovp_mv;
        input sel;
        begin
            ovp_mv = sel ? `MPC_OVP_HIGH_MV : `MPC_OVP_LOW_MV;
        end
    endfunction

    function [9:0] pg_hi_mv;
        input sel;
        begin
            pg_hi_mv = sel ? `MPC_PG_HI_WIDE_MV : `MPC_PG_HI_NARROW_MV;
        end
    endfunction

    function [9:0] pg_lo_mv;
        input sel;
        begin
            pg_lo_mv = sel ? `MPC_PG_LO_WIDE_MV : `MPC_PG_LO_NARROW_MV;
        end
    endfunction

    // Pin synchronisers and edge history
    reg scl_m_q, scl_s_q, scl_p_q;
    reg sda_m_q, sda_s_q, sda_p_q;

    always @(posedge sys_clk) begin
        if (!rstn) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;

    // Bus state
    reg [2:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] rx_q;
    reg [7:0] tx_q;
    reg [1:0] ptr_q;
    reg rd_first_q;
    reg mack_q;
    reg [1:0] pend_q;
    reg [7:0] stage_nb_q, stage_core_q;
    reg [7:0] cfg_nb_q, cfg_core_q;
    reg [7:0] rd_byte;

    always @* begin
        case (ptr_q)
            2'd0: rd_byte = cfg_nb_q;
            2'd1: rd_byte = cfg_core_q;
            default: rd_byte = 8'h00;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 2'h0;
            rd_first_q <= 1'b0;
            mack_q <= 1'b0;
            pend_q <= 2'h0;
            stage_nb_q <= `MPC_CFG_RESET;
            stage_core_q <= `MPC_CFG_RESET;
            cfg_nb_q <= `MPC_CFG_RESET;
            cfg_core_q <= `MPC_CFG_RESET;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
            cfg_update <= 1'b0;
        end else begin
            cfg_update <= 1'b0;
            sda_o <= 1'b0;
            if (start_det) begin
                state_q <= ST_DEV;
                // First clock fall after start wraps the count to zero
                bit_cnt_q <= 4'hf;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state_q <= ST_IDLE;
                sda_oe <= 1'b0;
                if (pend_q[0]) begin
                    cfg_nb_q <= stage_nb_q;
                end
                if (pend_q[1]) begin
                    cfg_core_q <= stage_core_q;
                end
                pend_q <= 2'h0;
                cfg_update <= |pend_q;
            end else if (state_q != ST_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt_q != 4'd8) begin
                        rx_q <= {rx_q[6:0], sda_s_q};
                    end else begin
                        mack_q <= ~sda_s_q;
                    end
                end
                if (scl_fall) begin
                    if (bit_cnt_q == 4'd7) begin
                        bit_cnt_q <= 4'd8;
                        case (state_q)
                            ST_DEV: begin
                                if (rx_q[7:1] == SLAVE_ADDR) begin
                                    sda_oe <= 1'b1;
                                    rd_first_q <= 1'b1;
                                    state_q <= rx_q[0] ? ST_RDAT : ST_REG;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end
                            ST_REG: begin
                                if (rx_q == `MPC_REG_NB || rx_q == `MPC_REG_CORE) begin
                                    ptr_q <= rx_q[1:0];
                                    sda_oe <= 1'b1;
                                    state_q <= ST_WDAT;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end
                            ST_WDAT: begin
                                if (ptr_q == 2'd0) begin
                                    stage_nb_q <= rx_q;
                                    pend_q[0] <= 1'b1;
                                end
                                if (ptr_q == 2'd1) begin
                                    stage_core_q <= rx_q;
                                    pend_q[1] <= 1'b1;
                                end
                                if (ptr_q != 2'd2) begin
                                    ptr_q <= ptr_q + 2'd1;
                                    sda_oe <= 1'b1;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end
                            default: begin
                                sda_oe <= 1'b0;
                            end
                        endcase
                    end else if (bit_cnt_q == 4'd8) begin
                        bit_cnt_q <= 4'h0;
                        sda_oe <= 1'b0;
                        if (state_q == ST_RDAT) begin
                            if (rd_first_q || mack_q) begin
                                rd_first_q <= 1'b0;
                                sda_oe <= ~rd_byte[7];
                                tx_q <= {rd_byte[6:0], 1'b0};
                                if (ptr_q != 2'd2) begin
                                    ptr_q <= ptr_q + 2'd1;
                                end
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end else begin
                        bit_cnt_q <= bit_cnt_q + 4'd1;
                        if (state_q == ST_RDAT) begin
                            sda_oe <= ~tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
            end
        end
    end

    // Field decode, same layout for both registers
    always @(posedge sys_clk) begin
        if (!rstn) begin
            nb_ovp_sel <= 1'b0;
            nb_pgood_sel <= 1'b0;
            nb_offset_code <= 6'h00;
            nb_offset_mv <= 11'sd0;
            nb_ovp_margin_mv <= `MPC_OVP_LOW_MV;
            nb_pgood_hi_mv <= `MPC_PG_HI_NARROW_MV;
            nb_pgood_lo_mv <= `MPC_PG_LO_NARROW_MV;
            core_ovp_sel <= 1'b0;
            core_pgood_sel <= 1'b0;
            core_offset_code <= 6'h00;
            core_offset_mv <= 11'sd0;
            core_ovp_margin_mv <= `MPC_OVP_LOW_MV;
            core_pgood_hi_mv <= `MPC_PG_HI_NARROW_MV;
            core_pgood_lo_mv <= `MPC_PG_LO_NARROW_MV;
            ovp_floor_mv <= `MPC_OVP_FLOOR_MV;
            pgood_hyst_mv <= `MPC_PG_HYST_MV;
        end else begin
            // Sources change only on commit or reset
            nb_ovp_sel <= cfg_nb_q[`MPC_OVP_BIT];
            nb_pgood_sel <= cfg_nb_q[`MPC_PG_BIT];
            nb_offset_code <= cfg_nb_q[`MPC_OFS_MSB:`MPC_OFS_LSB];
            nb_offset_mv <= offset_mv(cfg_nb_q[`MPC_OFS_MSB:`MPC_OFS_LSB]);
            nb_ovp_margin_mv <= ovp_mv(cfg_nb_q[`MPC_OVP_BIT]);
            nb_pgood_hi_mv <= pg_hi_mv(cfg_nb_q[`MPC_PG_BIT]);
            nb_pgood_lo_mv <= pg_lo_mv(cfg_nb_q[`MPC_PG_BIT]);
            core_ovp_sel <= cfg_core_q[`MPC_OVP_BIT];
            core_pgood_sel <= cfg_core_q[`MPC_PG_BIT];
            core_offset_code <= cfg_core_q[`MPC_OFS_MSB:`MPC_OFS_LSB];
            core_offset_mv <= offset_mv(cfg_core_q[`MPC_OFS_MSB:`MPC_OFS_LSB]);
            core_ovp_margin_mv <= ovp_mv(cfg_core_q[`MPC_OVP_BIT]);
            core_pgood_hi_mv <= pg_hi_mv(cfg_core_q[`MPC_PG_BIT]);
            core_pgood_lo_mv <= pg_lo_mv(cfg_core_q[`MPC_PG_BIT]);
            ovp_floor_mv <= `MPC_OVP_FLOOR_MV;
            pgood_hyst_mv <= `MPC_PG_HYST_MV;
        end
    end

endmodule // mpc_margin_config
